// ===== src/irpc_pkg.sv
// Package for the interrupt, reset and power control block.
// Assumes one 40 MHz clock; shared by the top module and the bench.
package irpc_pkg;
	localparam logic [7:0] OFF_TSC    = 8'h09;
	localparam logic [7:0] OFF_PRESC  = 8'hfd;
	localparam logic [7:0] OFF_TCOUNT = 8'hfe;
	localparam logic [7:0] OFF_CTRL   = 8'h10;
	localparam logic [7:0] OFF_STAT   = 8'h11;
	localparam logic [7:0] OFF_CMD    = 8'h12;
	// timer_status_control fields
	localparam int BIT_ZERO  = 7;
	localparam int BIT_TIE   = 6;
	localparam int BIT_TOUT  = 5;
	localparam int BIT_DOUT  = 4;
	localparam int BIT_PRUN  = 3;
	// ctrl register fields
	localparam int BIT_LEVEL = 0;
	localparam int BIT_DIVLO = 1;
	// cmd register fields (write-one pulses)
	localparam int CMD_DEEP  = 0;
	localparam int CMD_LIGHT = 1;
	localparam int CMD_SVC   = 2;
	localparam int CMD_RTI   = 3;
	localparam int CMD_MCLR  = 4;
	localparam logic [7:0] TSC_RST   = 8'h00;
	localparam logic [6:0] PRESC_RST = 7'h7f;
	localparam logic [7:0] TCNT_RST  = 8'hff;
	localparam logic [7:0] ROM_BLANK = 8'h00;
	localparam logic [11:0] IRQ_VECTOR = 12'hffc;
	localparam logic [11:0] RST_VECTOR = 12'hffe;
	localparam int PHASE_DIV   = 12;
	localparam int POR_CYCLES  = 1920;
	localparam int STAB_CYCLES = 1920;
	localparam int LAT_MAX     = 8;
	typedef enum {PM_RUN, PM_DEEP, PM_STAB, PM_LIGHT} irpc_pm_t;
	typedef enum logic [1:0] {MD_NORMAL, MD_SELF, MD_VERIFY} irpc_mode_t;
	typedef struct packed {
		logic [7:0] address;
		logic       read;
		logic       write;
		logic [7:0] writedata;
	} irpc_bus_req_t;
endpackage

// ===== src/irpc_top.sv
// Interrupt request, reset, sleep and clock division control.
// Assumes pins already synchronous to clock; Avalon-MM slave, 8-bit data.
//
// Contract
// - Level option checks the live interrupt pin level before starting service.
// - Interrupt mask stays set through power-up until software clears it.
// - Interrupt response within eight machine cycles.
// - Timer request on rising count_zero_flag, by count reaching zero or write.
// - Timer request gated by timer_irq_enable bit 6; reset clears it.
// - Request latch holds one request; a later one overwrites it.
// - Deep sleep stops the oscillator and all processing.
// - Deep sleep keeps timer_status_control and stored data.
// - Deep sleep wakes only on low interrupt or reset pin.
// - Deep sleep exit times a stabilisation delay on the timer.
// - Light sleep gates clock off all logic but the timer.
// - Timer counts in light sleep while prescaler_run is set.
// - Light sleep exits on reset, external or enabled timer interrupt.
// - Unimplemented program ROM reads as zero.
// - Power-on counts 1920 oscillator cycles before releasing reset.
// - Pin still low after power-on delay holds reset.
// - Pin reset needs two low cycles and no delay.
// - Reset loads timer registers, clears latches, flags, loads restart vector.
// - Oscillator divided by 1, 2 or 4 into phase clock.
// - Phase clock divided by twelve into machine cycles.
// - Both interrupts share one vector; count_zero_flag tells them apart.
// - Edge option: low pin sets request latch, tested before each fetch.
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module irpc_top
	import irpc_pkg::*;
#(
	parameter int DIV_SEL    = 1,
	parameter int POR_COUNT  = POR_CYCLES,
	parameter int STAB_COUNT = STAB_CYCLES,
	parameter logic [11:0] ROM_TOP = 12'h7ff
) (
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [7:0]  avs_writedata,
	output logic      [7:0]  avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        irq_pin_n,
	input  wire logic        reset_pin_n,
	input  wire logic        mode_select_pin,
	input  wire logic        port_a_bit7,
	input  wire logic        port_a_bit6,
	input  wire logic [11:0] rom_addr,
	input  wire logic [7:0]  rom_data,
	output logic      [7:0]  rom_q,
	output logic             osc_enable,
	output logic             cpu_clk_enable,
	output logic             internal_reset,
	output logic             machine_cycle,
	output logic             service_start,
	output logic      [11:0] fetch_vector,
	output logic      [1:0]  test_mode
);
	initial begin
		if (!(DIV_SEL == 1 || DIV_SEL == 2 || DIV_SEL == 4))
			$error("DIV_SEL must be 1, 2 or 4");
		if (POR_COUNT < 1 || POR_COUNT > 65535 || STAB_COUNT < 1 || STAB_COUNT > 65535)
			$error("delay counts out of range");
	end

	// Reset release through two flops
	logic rst_s1, rst_s2;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rst_s1 <= 1'b0;
			rst_s2 <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_s2 <= rst_s1;
		end
	end
	wire rst_n = rst_s2;

	irpc_bus_req_t req;
	assign req = '{address: avs_address, read: avs_read, write: avs_write,
		writedata: avs_writedata};

	// One wait state on reads, writes in zero
	logic rd_done_reg;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rd_done_reg <= 1'b0;
		end else begin
			rd_done_reg <= req.read && !rd_done_reg;
		end
	end
	assign avs_waitrequest = req.read && !rd_done_reg;
	wire rd_take = req.read && rd_done_reg;
	wire wr_take = req.write;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction
	wire wr_tsc  = wr_take && hit(req.address, OFF_TSC);
	wire wr_pre  = wr_take && hit(req.address, OFF_PRESC);
	wire wr_tcnt = wr_take && hit(req.address, OFF_TCOUNT);
	wire wr_ctrl = wr_take && hit(req.address, OFF_CTRL);
	wire wr_cmd  = wr_take && hit(req.address, OFF_CMD);
	wire rd_tsc  = rd_take && hit(req.address, OFF_TSC);

	// Reset sequencing: power-on delay, pin reset, strap capture
	logic [15:0] por_cnt_reg;
	logic        por_done_reg;
	logic [1:0]  pin_low_reg;
	irpc_mode_t  mode_reg;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			por_cnt_reg  <= 16'h0000;
			por_done_reg <= 1'b0;
			pin_low_reg  <= 2'b00;
		end else begin
			pin_low_reg <= {pin_low_reg[0], !reset_pin_n};
			if (!por_done_reg) begin
				por_cnt_reg <= por_cnt_reg + 16'h0001;
				if (por_cnt_reg == 16'(POR_COUNT - 1))
					por_done_reg <= 1'b1;
			end
		end
	end
	// Pin reset after two low cycles, held while pin low
	wire pin_rst = &pin_low_reg || (pin_low_reg[0] && !reset_pin_n);
	wire int_rst = !por_done_reg || pin_rst || !reset_pin_n && !por_done_reg;
	assign internal_reset = int_rst || (!reset_pin_n && pin_low_reg[0]);

	// Strap decode while reset is applied
	irpc_mode_t mode_next;
	always_comb begin
		mode_next = mode_reg;
		if (internal_reset) begin
			if (mode_select_pin && port_a_bit7) begin
				mode_next = port_a_bit6 ? MD_VERIFY : MD_SELF;
			end else begin
				mode_next = MD_NORMAL;
			end
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mode_reg <= MD_NORMAL;
		end else begin
			mode_reg <= mode_next;
		end
	end
	assign test_mode = mode_reg;

	// Clock division: phase clock, then machine cycle
	localparam int DW = 2;
	logic [DW-1:0] div_reg;
	logic [3:0]    ph_reg;
	irpc_pm_t      pm_reg;
	wire osc_run   = (pm_reg != PM_DEEP);
	wire phase_tick = osc_run && (div_reg == DW'(DIV_SEL - 1));
	wire mc_tick   = phase_tick && (ph_reg == 4'(PHASE_DIV - 1));
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			div_reg <= '0;
			ph_reg  <= 4'h0;
		end else if (osc_run) begin
			div_reg <= phase_tick ? '0 : div_reg + DW'(1);
			if (phase_tick)
				ph_reg <= mc_tick ? 4'h0 : ph_reg + 4'h1;
		end
	end
	assign machine_cycle = mc_tick;
	assign osc_enable    = osc_run;

	// Timer registers
	logic [7:0] tsc_reg, tcnt_reg;
	logic [6:0] pre_reg;
	logic [7:0] ctrl_reg;
	logic [15:0] stab_reg;
	wire tick_en = mc_tick && tsc_reg[BIT_PRUN] && pm_reg != PM_STAB;
	wire pre_wrap = tick_en && (pre_reg == 7'h00);
	wire cnt_zero = pre_wrap && (tcnt_reg == 8'h01) && !wr_tcnt && !wr_pre;
	wire zero_set = cnt_zero || (wr_tsc && req.writedata[BIT_ZERO])
		|| (wr_tcnt && req.writedata == 8'h00);
	wire zero_rd_clr = rd_tsc && tsc_reg[BIT_ZERO];
	wire zero_rise = zero_set && !tsc_reg[BIT_ZERO];
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tsc_reg  <= TSC_RST;
			tcnt_reg <= TCNT_RST;
			pre_reg  <= PRESC_RST;
			ctrl_reg <= 8'h00;
		end else if (internal_reset) begin
			tsc_reg  <= TSC_RST;
			tcnt_reg <= TCNT_RST;
			pre_reg  <= PRESC_RST;
		end else begin
			if (wr_tsc) tsc_reg[6:0] <= req.writedata[6:0];
			// Set wins over read-clear
			if (zero_set) begin
				tsc_reg[BIT_ZERO] <= 1'b1;
			end else if (zero_rd_clr) begin
				tsc_reg[BIT_ZERO] <= 1'b0;
			end
			if (wr_ctrl) begin
				ctrl_reg <= req.writedata;
			end
			// Deep-sleep exit delay uses timer; contents left as counted
			if (wr_pre) pre_reg <= req.writedata[6:0];
			else if (pm_reg == PM_STAB && phase_tick) pre_reg <= pre_reg - 7'h01;
			else if (!tsc_reg[BIT_PRUN]) pre_reg <= PRESC_RST;
			else if (tick_en) pre_reg <= pre_reg - 7'h01;
			if (wr_tcnt) tcnt_reg <= req.writedata;
			else if (pm_reg == PM_STAB && phase_tick && pre_reg == 7'h00)
				tcnt_reg <= tcnt_reg - 8'h01;
			else if (pre_wrap) tcnt_reg <= tcnt_reg - 8'h01;
		end
	end

	// Interrupt latch, mask, service
	logic req_latch_reg, mask_reg, timer_req_reg;
	logic [3:0] wait_mc_reg;
	wire ext_req   = !irq_pin_n;
	wire timer_req = zero_rise && tsc_reg[BIT_TIE];
	wire level_opt = ctrl_reg[BIT_LEVEL];
	wire pending   = level_opt ? (req_latch_reg && ext_req) || timer_req_reg
		: req_latch_reg;
	wire svc_cmd   = wr_cmd && req.writedata[CMD_SVC];
	wire take_irq  = pending && !mask_reg && pm_reg == PM_RUN
		&& (svc_cmd || wait_mc_reg == 4'(LAT_MAX - 1));
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			req_latch_reg <= 1'b0;
			timer_req_reg <= 1'b0;
			mask_reg      <= 1'b1;
			wait_mc_reg   <= 4'h0;
		end else if (internal_reset) begin
			req_latch_reg <= 1'b0;
			timer_req_reg <= 1'b0;
			mask_reg      <= 1'b1;
			wait_mc_reg   <= 4'h0;
		end else begin
			// New request sets latch; set wins over the service clear
			if (ext_req || timer_req)
				req_latch_reg <= 1'b1;
			else if (take_irq)
				req_latch_reg <= 1'b0;
			if (timer_req) begin
				timer_req_reg <= 1'b1;
			end else if (take_irq) begin
				timer_req_reg <= 1'b0;
			end
			if (take_irq) mask_reg <= 1'b1;
			else if (wr_cmd && (req.writedata[CMD_RTI] || req.writedata[CMD_MCLR]
				|| req.writedata[CMD_DEEP] || req.writedata[CMD_LIGHT]))
				mask_reg <= 1'b0;
			if (!pending || mask_reg || take_irq) begin
				wait_mc_reg <= 4'h0;
			end else if (mc_tick && pm_reg == PM_RUN) begin
				wait_mc_reg <= wait_mc_reg + 4'h1;
			end
		end
	end
	assign service_start = take_irq;

	// Sleep sequencing
	irpc_pm_t    pm_next;
	logic [15:0] stab_next;
	always_comb begin
		pm_next   = pm_reg;
		stab_next = stab_reg;
		unique case (pm_reg)
			PM_RUN: begin
				if (wr_cmd && req.writedata[CMD_DEEP]) begin
					pm_next = PM_DEEP;
				end else if (wr_cmd && req.writedata[CMD_LIGHT]) begin
					pm_next = PM_LIGHT;
				end
			end
			PM_DEEP: begin
				stab_next = 16'h0000;
				if (ext_req) begin
					pm_next = PM_STAB;
				end
			end
			PM_STAB: begin
				stab_next = stab_reg + 16'h0001;
				if (stab_reg == 16'(STAB_COUNT - 1)) begin
					pm_next = PM_RUN;
				end
			end
			PM_LIGHT: begin
				if (ext_req || timer_req) begin
					pm_next = PM_RUN;
				end
			end
		endcase
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pm_reg   <= PM_RUN;
			stab_reg <= 16'h0000;
		end else if (internal_reset) begin
			pm_reg   <= PM_RUN;
			stab_reg <= 16'h0000;
		end else begin
			pm_reg   <= pm_next;
			stab_reg <= stab_next;
		end
	end
	// Deep sleep stops only the divider via osc_enable; bus and other registers stay clocked
	assign cpu_clk_enable = (pm_reg == PM_RUN) && !internal_reset;
	assign fetch_vector = internal_reset ? RST_VECTOR : IRQ_VECTOR;

	// Program ROM: unimplemented area reads blank
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rom_q <= ROM_BLANK;
		end else begin
			rom_q <= (rom_addr > ROM_TOP) ? ROM_BLANK : rom_data;
		end
	end

	// Register read mux
	logic [7:0] rd_mux;
	always_comb begin
		rd_mux = 8'h00;
		if (hit(req.address, OFF_TSC))    rd_mux = tsc_reg;
		if (hit(req.address, OFF_PRESC))  rd_mux = {1'b0, pre_reg};
		if (hit(req.address, OFF_TCOUNT)) rd_mux = tcnt_reg;
		if (hit(req.address, OFF_CTRL))   rd_mux = ctrl_reg;
		if (hit(req.address, OFF_STAT))
			rd_mux = {mode_reg, 2'(pm_reg), mask_reg, req_latch_reg, timer_req_reg, 1'b0};
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata <= 8'h00;
		end else if (req.read && !rd_done_reg) begin
			avs_readdata <= rd_mux;
		end
	end
endmodule // irpc_top
`default_nettype wire

// ===== bench/irpc_assertions.sv
// Port checks for the interrupt, reset and power control block.
// Bound into irpc_top; expects a stabilisation count of at least eight.
`timescale 1ns/1ps
`default_nettype none
module irpc_checker
	import irpc_pkg::*;
#(
	parameter int          POR_COUNT = 20,
	parameter logic [11:0] ROM_TOP   = 12'h7ff
) (
	input wire logic        clock,
	input wire logic        resetn,
	input wire logic        irq_pin_n,
	input wire logic        reset_pin_n,
	input wire logic [11:0] rom_addr,
	input wire logic [7:0]  rom_data,
	input wire logic [7:0]  rom_q,
	input wire logic        osc_enable,
	input wire logic        cpu_clk_enable,
	input wire logic        internal_reset,
	input wire logic        machine_cycle,
	input wire logic        service_start,
	input wire logic [11:0] fetch_vector
);
	logic [15:0] por_reg;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			por_reg <= 16'h0;
		else if (por_reg != 16'hffff)
			por_reg <= por_reg + 16'h1;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	property p_vec; fetch_vector == (internal_reset ? RST_VECTOR : IRQ_VECTOR); endproperty
	a_vec: assert property (p_vec) else $error("bad vector");
	property p_por; por_reg < POR_COUNT |-> internal_reset; endproperty
	a_por: assert property (p_por) else $error("early release");
	property p_rom; !internal_reset && osc_enable |=>
		rom_q == (($past(rom_addr) > ROM_TOP) ? ROM_BLANK : $past(rom_data)); endproperty
	a_rom: assert property (p_rom) else $error("bad rom data");
	property p_mcyc; machine_cycle |=> !machine_cycle [*8]; endproperty
	a_mcyc: assert property (p_mcyc) else $error("short cycle");
	property p_hold; internal_reset && !reset_pin_n |=> internal_reset; endproperty
	a_hold: assert property (p_hold) else $error("reset dropped");
	property p_pin; !reset_pin_n [*4] |-> internal_reset && !service_start; endproperty
	a_pin: assert property (p_pin) else $error("no pin reset");
	property p_wake; !osc_enable && irq_pin_n && reset_pin_n && $past(irq_pin_n)
		&& $past(reset_pin_n) |=> !osc_enable && !cpu_clk_enable; endproperty
	a_wake: assert property (p_wake) else $error("bad wake");
	property p_stab; $rose(osc_enable) |-> !cpu_clk_enable [*8]; endproperty
	a_stab: assert property (p_stab) else $error("no delay");
	c_svc: cover property (service_start);
	c_wake: cover property (!osc_enable ##1 osc_enable);
	c_pin: cover property (!reset_pin_n [*4]);
endmodule // irpc_checker
bind irpc_top irpc_checker #(.POR_COUNT(POR_COUNT), .ROM_TOP(ROM_TOP)) irpc_checker_inst (.*);
`default_nettype wire

// ===== bench/irpc_pins.sv
// Board model driving interrupt, reset and strap pins.
// Requests come from the bench; straps wander outside reset.
`timescale 1ns/1ps
`default_nettype none
module irpc_pins (
	input  wire logic       clock,
	input  wire logic       irq_req,
	input  wire logic       rst_req,
	input  wire logic [2:0] strap,
	input  wire logic       internal_reset,
	output var  logic       irq_pin_n,
	output var  logic       reset_pin_n,
	output var  logic       mode_select_pin,
	output var  logic       port_a_bit7,
	output var  logic       port_a_bit6
);
	logic [2:0] walk_reg = 3'h0;
	initial {irq_pin_n, reset_pin_n, mode_select_pin, port_a_bit7, port_a_bit6} = 5'h18;
	always @(posedge clock) begin
		irq_pin_n <= !irq_req;
		reset_pin_n <= !rst_req;
		walk_reg <= walk_reg + 3'h1;
		if (internal_reset || !reset_pin_n)
			{mode_select_pin, port_a_bit7, port_a_bit6} <= strap;
		else
			{mode_select_pin, port_a_bit7, port_a_bit6} <= walk_reg;
	end
endmodule // irpc_pins
`default_nettype wire

// ===== bench/tb.sv
// Self-checking bench for the interrupt, reset and power control block.
// Assumes short power-on and stabilisation counts of twenty clocks.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import irpc_pkg::*;
	localparam int          POR = 20;
	localparam logic [11:0] ROM_LIM = 12'h7ff;
	logic        clock = 1'b0, resetn = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
	logic [7:0]  avs_address = 8'h0, avs_writedata = 8'h0, avs_readdata, rd;
	logic        avs_waitrequest, irq_pin_n, reset_pin_n, mode_select_pin, port_a_bit7;
	logic        port_a_bit6, irq_req = 1'b0, rst_req = 1'b0, osc_enable, cpu_clk_enable;
	logic        internal_reset, machine_cycle, service_start;
	logic [2:0]  strap = 3'h0;
	logic [11:0] rom_addr = 12'h0, fetch_vector;
	logic [7:0]  rom_data = 8'h0, rom_q, cnt_m;
	logic [1:0]  test_mode;
	logic [1:0]  mode_m [3] = '{MD_NORMAL, MD_SELF, MD_VERIFY};
	logic [2:0]  strap_m [3] = '{3'h0, 3'h6, 3'h7};
	int          n_errors = 0, compares = 0, seed = 10, n;
	always #12.5 clock = ~clock;
	irpc_top #(.POR_COUNT(POR), .STAB_COUNT(POR), .ROM_TOP(ROM_LIM)) irpc_top_inst (.*);
	irpc_pins irpc_pins_inst (.*);
	task automatic finish_test;
		if (n_errors == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
		end
	endtask
	function automatic logic sig(input int k);
		case (k)
			0: return internal_reset;
			1: return osc_enable;
			2: return cpu_clk_enable;
			default: return service_start;
		endcase
	endfunction
	task automatic wt(input int k, input logic v, input int lim);
		int i;
		i = 0;
		while (sig(k) !== v) begin
			@(posedge clock);
			#1;
			i++;
			if (i > lim) begin
				chk("wait", {7'h0, v}, {7'h0, sig(k)});
				finish_test;
			end
		end
	endtask
	task automatic hold(input int k, input logic v, input int c);
		repeat (c) begin
			@(posedge clock);
			#1;
			chk("level", {7'h0, v}, {7'h0, sig(k)});
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		int i;
		i = 0;
		@(posedge clock);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do begin
			@(posedge clock);
			i++;
		end while (avs_waitrequest !== 1'b0 && i < 40);
		if (i >= 40) begin
			chk("waitrequest", 8'h0, 8'h1);
			finish_test;
		end
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h0);
		chk("readdata", e, rd);
	endtask
	initial begin
		repeat (4) @(posedge clock);
		resetn <= 1'b1;
		wt(0, 1'b0, POR + 40);
		rdc(OFF_TSC, TSC_RST);
		rdc(OFF_PRESC, {1'b0, PRESC_RST});
		rdc(OFF_TCOUNT, TCNT_RST);
		rdc(8'h3f, 8'h00);
		repeat (24) begin
			@(posedge clock);
			rom_addr <= 12'($random(seed));
			rom_data <= 8'($random(seed));
			@(posedge clock);
			#1;
			chk("rom_q", (rom_addr > ROM_LIM) ? 8'h00 : rom_data, rom_q);
		end
		bus(1'b1, OFF_TSC, 8'h40);
		hold(3, 1'b0, 120);
		bus(1'b1, OFF_CMD, 8'h10);
		bus(1'b1, OFF_TSC, 8'hc0);
		wt(3, 1'b1, 8 * PHASE_DIV + 30);
		bus(1'b1, OFF_TSC, 8'h00);
		bus(1'b0, OFF_TSC, 8'h00);
		bus(1'b1, OFF_CMD, 8'h08);
		bus(1'b1, OFF_TSC, 8'h80);
		hold(3, 1'b0, 120);
		rdc(OFF_TSC, 8'h80);
		bus(1'b1, OFF_TSC, 8'h40);
		bus(1'b1, OFF_CMD, 8'h01);
		wt(1, 1'b0, 10);
		hold(1, 1'b0, 30);
		irq_req <= 1'b1;
		wt(1, 1'b1, 20);
		wt(2, 1'b1, POR + 40);
		irq_req <= 1'b0;
		rdc(OFF_TSC, 8'h40);
		bus(1'b1, OFF_CMD, 8'h02);
		wt(2, 1'b0, 10);
		hold(2, 1'b0, 30);
		chk("osc_enable", 8'h1, {7'h0, osc_enable});
		irq_req <= 1'b1;
		wt(2, 1'b1, 40);
		irq_req <= 1'b0;
		cnt_m = 8'($random(seed)) | 8'h01;
		bus(1'b1, OFF_TCOUNT, cnt_m);
		rdc(OFF_TCOUNT, cnt_m);
		bus(1'b1, OFF_CTRL, 8'h01);
		rdc(OFF_CTRL, 8'h01);
		for (n = 0; n < 3; n++) begin
			strap <= strap_m[n];
			rst_req <= 1'b1;
			repeat (5) @(posedge clock);
			#1;
			chk("internal_reset", 8'h1, {7'h0, internal_reset});
			rst_req <= 1'b0;
			wt(0, 1'b0, 10);
			chk("test_mode", {6'h0, mode_m[n]}, {6'h0, test_mode});
			rdc(OFF_TCOUNT, TCNT_RST);
			rdc(OFF_TSC, TSC_RST);
		end
		finish_test;
	end
endmodule // tb
`default_nettype wire
